// ### verilog/eip_pkg.sv
/*
  Package for the extended interrupt enable / priority block:
  special-function register addresses, reset values, bit positions
  and the service-state encoding.
  Assumes an 8-bit special-function register bus and a core that
  acknowledges and returns from interrupts with one-cycle pulses.
*/
package eip_pkg;

  // ==========================================================
  // register addresses and reset values
  localparam logic [7:0] EIP_ADDR_ENABLE   = 8'hE6;
  localparam logic [7:0] EIP_ADDR_PRIORITY = 8'hF6;
  localparam logic [7:0] EIP_ENABLE_RST    = 8'h00;
  localparam logic [7:0] EIP_PRIORITY_RST  = 8'h00;
  localparam logic [7:0] EIP_UNMAPPED_DATA = 8'h00;

  // ==========================================================
  // source bit positions, shared by both registers
  localparam int EIP_BIT_CONV_DONE = 7;
  localparam int EIP_BIT_CMP2      = 6;
  localparam int EIP_BIT_CMP1      = 5;
  localparam int EIP_BIT_CMP0      = 4;
  localparam int EIP_BIT_CNT_ARRAY = 3;
  localparam int EIP_BIT_WINDOW    = 2;
  localparam int EIP_BIT_MGMT_BUS  = 1;
  localparam int EIP_BIT_SER_PERIPH = 0;

  localparam int EIP_NUM_SRC = 8;
  localparam int EIP_SRC_W   = 3;

  // ==========================================================
  // service state, one-hot
  typedef enum logic [3:0] {
    EIP_IDLE     = 4'h1,
    EIP_SVC_LOW  = 4'h2,
    EIP_SVC_HIGH = 4'h4,
    EIP_SVC_NEST = 4'h8
  } eip_state_t;

endpackage

// ### verilog/eip_src_gate.sv
/*
  One interrupt source: masks its pending flag with the enable bit
  and steers it to the high or the low request level.
  Purely combinational; pending is a level held by the peripheral.
*/
`timescale 1ns/10ps
module eip_src_gate
  import eip_pkg::*;
(
  input  wire logic pending,
  input  wire logic enable,
  input  wire logic highLevel,
  output logic      reqHigh,
  output logic      reqLow
);

  // ==========================================================
  // mask, then split by priority level
  assign reqHigh = pending & enable & highLevel;
  assign reqLow  = pending & enable & ~highLevel;

endmodule

// ### verilog/eip_irq_ctrl.sv
/*
  Extended interrupt enable and priority registers with a two-level
  request presenter for eight peripheral sources.
  Assumes the core drives the special-function bus synchronously,
  pulses irqAck only while irqValid is high and pulses irqReturn
  once per finished service routine.

// What this block does
// - enable register bits 7..0 mask conv-done, cmp2, cmp1, cmp0, counter, window, bus, spi.
// - reset clears the whole enable register so every source starts masked.
// - enable bit 7 blocks or passes the conversion-done request to the core.
// - priority register holds one read/write level bit per source, same order.
// - priority bit 5 puts comparator 1 at low level when 0, high when 1.
// - priority bit 4 puts comparator 0 at low level when 0, high when 1.
*/
`timescale 1ns/10ps
module eip_irq_ctrl
  import eip_pkg::*;
#(
  parameter int NUM_SRC = EIP_NUM_SRC
)
(
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic                 clkEn,
  input  wire logic [7:0]           sfrAddr,
  input  wire logic [7:0]           sfrWrData,
  input  wire logic                 sfrWr,
  input  wire logic                 sfrRd,
  output logic      [7:0]           sfrRdData,
  input  wire logic [NUM_SRC-1:0]   srcPending,
  input  wire logic                 irqAck,
  input  wire logic                 irqReturn,
  output logic                      irqValid,
  output logic      [EIP_SRC_W-1:0] irqSrc,
  output logic                      irqIsHigh,
  output logic      [NUM_SRC-1:0]   enableOut,
  output logic      [NUM_SRC-1:0]   priorityOut
);

  // ==========================================================
  // state record
  typedef struct packed {
    logic [7:0]           enable;
    logic [7:0]           prio;
    eip_state_t           svc;
    logic                 valid;
    logic [EIP_SRC_W-1:0] src;
    logic                 isHigh;
    logic [7:0]           rdData;
  } eip_regs_t;

  eip_regs_t regs_ff;
  eip_regs_t nxt_regs;

  logic [NUM_SRC-1:0] reqHigh;
  logic [NUM_SRC-1:0] reqLow;
  logic               anyHigh;
  logic               anyLow;
  logic [EIP_SRC_W-1:0] pickHigh;
  logic [EIP_SRC_W-1:0] pickLow;

  // ==========================================================
  // per-source masking and level steering
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++)
    begin : gSrc
      eip_src_gate uGate (
        .pending   (srcPending[g]),
        .enable    (regs_ff.enable[g]),
        .highLevel (regs_ff.prio[g]),
        .reqHigh   (reqHigh[g]),
        .reqLow    (reqLow[g])
      );
    end
  endgenerate

  // lowest index wins inside a level; a fixed order keeps the choice stable
  function automatic logic [EIP_SRC_W-1:0] pick_first(input logic [NUM_SRC-1:0] req);
    logic [EIP_SRC_W-1:0] idx;
    idx = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        idx = EIP_SRC_W'(i);
      end
    end
    return idx;
  endfunction

  assign anyHigh  = |reqHigh;
  assign anyLow   = |reqLow;
  assign pickHigh = pick_first(reqHigh);
  assign pickLow  = pick_first(reqLow);

  // ==========================================================
  // next-state logic: register file, service tracking, presenter
  always_comb
  begin
    nxt_regs = regs_ff;
    // register writes
    if (sfrWr)
    begin
      if (sfrAddr == EIP_ADDR_ENABLE)
      begin
        nxt_regs.enable = sfrWrData;
      end
      if (sfrAddr == EIP_ADDR_PRIORITY)
      begin
        nxt_regs.prio = sfrWrData;
      end
    end
    // register reads: registered, unmapped addresses read zero
    if (sfrRd)
    begin
      if (sfrAddr == EIP_ADDR_ENABLE)
      begin
        nxt_regs.rdData = regs_ff.enable;
      end
      else if (sfrAddr == EIP_ADDR_PRIORITY)
      begin
        nxt_regs.rdData = regs_ff.prio;
      end
      else
      begin
        nxt_regs.rdData = EIP_UNMAPPED_DATA;
      end
    end
    // service level tracking
    case (regs_ff.svc)
      EIP_IDLE:
      begin
        if (irqAck && regs_ff.valid)
        begin
          nxt_regs.svc = regs_ff.isHigh ? EIP_SVC_HIGH : EIP_SVC_LOW;
        end
      end
      EIP_SVC_LOW:
      begin
        if (irqReturn)
        begin
          nxt_regs.svc = EIP_IDLE;
        end
        else if (irqAck && regs_ff.valid && regs_ff.isHigh)
        begin
          nxt_regs.svc = EIP_SVC_NEST;
        end
      end
      EIP_SVC_HIGH:
      begin
        if (irqReturn)
        begin
          nxt_regs.svc = EIP_IDLE;
        end
      end
      EIP_SVC_NEST:
      begin
        if (irqReturn)
        begin
          nxt_regs.svc = EIP_SVC_LOW;
        end
      end
      default:
      begin
        nxt_regs.svc = EIP_IDLE;
      end
    endcase
    // presenter: withdraw for one cycle around ack/return so the new level is seen
    nxt_regs.valid  = 1'b0;
    nxt_regs.isHigh = 1'b0;
    nxt_regs.src    = regs_ff.src;
    if (!irqAck && !irqReturn)
    begin
      if (anyHigh && (regs_ff.svc == EIP_IDLE || regs_ff.svc == EIP_SVC_LOW))
      begin
        nxt_regs.valid  = 1'b1;
        nxt_regs.isHigh = 1'b1;
        nxt_regs.src    = pickHigh;
      end
      else if (anyLow && regs_ff.svc == EIP_IDLE)
      begin
        nxt_regs.valid  = 1'b1;
        nxt_regs.src    = pickLow;
      end
    end
  end

  // ==========================================================
  // state register; clock enable freezes everything
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      regs_ff.enable <= EIP_ENABLE_RST;
      regs_ff.prio   <= EIP_PRIORITY_RST;
      regs_ff.svc    <= EIP_IDLE;
      regs_ff.valid  <= 1'b0;
      regs_ff.src    <= '0;
      regs_ff.isHigh <= 1'b0;
      regs_ff.rdData <= 8'h00;
    end
    else if (clkEn)
    begin
      regs_ff <= nxt_regs;
    end
  end

  // ==========================================================
  // outputs, all from flip-flops
  assign sfrRdData   = regs_ff.rdData;
  assign irqValid    = regs_ff.valid;
  assign irqSrc      = regs_ff.src;
  assign irqIsHigh   = regs_ff.isHigh;
  assign enableOut   = regs_ff.enable;
  assign priorityOut = regs_ff.prio;

  // ==========================================================
  // assertions
  default clocking cbAssert @(posedge core_clk);
  endclocking
  default disable iff (rst);

  property p_enable_write;
    clkEn && sfrWr && sfrAddr == EIP_ADDR_ENABLE |=> regs_ff.enable == $past(sfrWrData);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable write lost");

  property p_enable_reset;
    $fell(rst) |-> regs_ff.enable == EIP_ENABLE_RST;
  endproperty
  a_enable_reset: assert property (p_enable_reset) else $error("enable not clear after reset");

  property p_conv_done_gate;
    irqValid && irqSrc == EIP_SRC_W'(EIP_BIT_CONV_DONE) |-> $past(regs_ff.enable[EIP_BIT_CONV_DONE]);
  endproperty
  a_conv_done_gate: assert property (p_conv_done_gate) else $error("masked conv-done presented");

  property p_prio_readback;
    clkEn && sfrWr && sfrAddr == EIP_ADDR_PRIORITY ##1 clkEn && sfrRd && !sfrWr
      && sfrAddr == EIP_ADDR_PRIORITY |=> sfrRdData == $past(sfrWrData, 2);
  endproperty
  a_prio_readback: assert property (p_prio_readback) else $error("priority readback wrong");

  property p_cmp2_level;
    srcPending[EIP_BIT_CMP2] && regs_ff.enable[EIP_BIT_CMP2]
      |-> reqHigh[EIP_BIT_CMP2] == regs_ff.prio[EIP_BIT_CMP2];
  endproperty
  a_cmp2_level: assert property (p_cmp2_level) else $error("cmp2 level wrong");

  property p_cmp1_level;
    srcPending[EIP_BIT_CMP1] && regs_ff.enable[EIP_BIT_CMP1] && !regs_ff.prio[EIP_BIT_CMP1]
      |-> reqLow[EIP_BIT_CMP1] && !reqHigh[EIP_BIT_CMP1];
  endproperty
  a_cmp1_level: assert property (p_cmp1_level) else $error("cmp1 level wrong");

  property p_cmp0_level;
    reqHigh[EIP_BIT_CMP0] |-> regs_ff.prio[EIP_BIT_CMP0] && srcPending[EIP_BIT_CMP0];
  endproperty
  a_cmp0_level: assert property (p_cmp0_level) else $error("cmp0 level wrong");

  property p_no_preempt_high;
    (regs_ff.svc == EIP_SVC_HIGH || regs_ff.svc == EIP_SVC_NEST) |=> !irqValid;
  endproperty
  a_no_preempt_high: assert property (p_no_preempt_high) else $error("request during high service");

  property p_high_preempts_low;
    clkEn && regs_ff.svc == EIP_SVC_LOW && anyHigh && !irqAck && !irqReturn |=> irqValid && irqIsHigh;
  endproperty
  a_high_preempts_low: assert property (p_high_preempts_low) else $error("high did not pre-empt");

  c_nest: cover property (regs_ff.svc == EIP_SVC_LOW ##[1:20] regs_ff.svc == EIP_SVC_NEST);
  c_low_served: cover property (irqValid && !irqIsHigh && irqAck);
  c_prio_write: cover property (sfrWr && sfrAddr == EIP_ADDR_PRIORITY);

endmodule

// ### dv/eip_core_model.sv
/*
  Behavioural model of the processor core interrupt side: acks a
  presented request after ackDelay cycles, returns after svcLen.
  Assumes the one-cycle ack/return pulses of the request link.
*/
`timescale 1ns/10ps
module eip_core_model
  import eip_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       irqValid,
  input  wire logic [7:0] ackDelay,
  input  wire logic [7:0] svcLen,
  output logic            irqAck,
  output logic            irqReturn,
  output logic [1:0]      depth
);
  logic [7:0] waitCnt;
  logic [7:0] tmr [2];
  // ==========================================================
  // ack and return sequencing; never both in one cycle
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      irqAck <= 1'b0;
      irqReturn <= 1'b0;
      depth <= 2'h0;
      waitCnt <= 8'h00;
    end
    else
    begin
      irqAck <= 1'b0;
      irqReturn <= 1'b0;
      if (irqAck)
      begin
        tmr[depth[0]] <= svcLen;
        depth <= depth + 2'h1;
        waitCnt <= 8'h00;
      end
      else if (irqReturn)
        waitCnt <= 8'h00;
      else if (irqValid && depth != 2'h2 && waitCnt >= ackDelay)
        irqAck <= 1'b1;
      else if (irqValid && depth != 2'h2)
        waitCnt <= waitCnt + 8'h01;
      else if (depth != 2'h0 && tmr[~depth[0]] == 8'h00)
      begin
        irqReturn <= 1'b1;
        depth <= depth - 2'h1;
      end
      else if (depth != 2'h0)
        tmr[~depth[0]] <= tmr[~depth[0]] - 8'h01;
    end
  end
endmodule

// ### dv/test_extended_irq_enable_priority.sv
/*
  Self-checking bench: register access, masking, level steering
  and nesting. Assumes the core model in eip_core_model.sv.
*/
`timescale 1ns/10ps
module test_extended_irq_enable_priority;
  import eip_pkg::*;
  logic       core_clk, rst, clkEn, sfrWr, sfrRd, irqValid, irqIsHigh, irqAck, irqReturn;
  logic [7:0] sfrAddr, sfrWrData, sfrRdData, enableOut, priorityOut;
  logic [7:0] pendReq, served, ackDelay, svcLen, shEn, shPr, rdv, d;
  logic [2:0] irqSrc;
  logic [1:0] depth;
  logic [3:0] expV;
  int         n_fail, cmp_count, nAck;
  // served sources drop their flag, as a peripheral would
  wire logic [7:0] srcPending = pendReq & ~served;

  eip_irq_ctrl uut (.core_clk(core_clk), .rst(rst), .clkEn(clkEn), .sfrAddr(sfrAddr),
    .sfrWrData(sfrWrData), .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrRdData(sfrRdData),
    .srcPending(srcPending), .irqAck(irqAck), .irqReturn(irqReturn), .irqValid(irqValid),
    .irqSrc(irqSrc), .irqIsHigh(irqIsHigh), .enableOut(enableOut), .priorityOut(priorityOut));
  eip_core_model core (.core_clk(core_clk), .rst(rst), .irqValid(irqValid), .ackDelay(ackDelay),
    .svcLen(svcLen), .irqAck(irqAck), .irqReturn(irqReturn), .depth(depth));

  // ==========================================================
  // expectation: high level first, lowest index within a level
  function automatic logic [3:0] expSrc(logic [7:0] p, logic [7:0] e, logic [7:0] h);
    for (int l = 1; l >= 0; l--)
      for (int i = 0; i < 8; i++)
        if (p[i] && e[i] && h[i] == l[0])
          return {1'b1, 3'(i)};
    return 4'h0;
  endfunction

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      n_fail++;
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    sfrAddr <= a;
    sfrWrData <= v;
    sfrWr <= 1'b1;
    @(posedge core_clk);
    sfrWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    sfrAddr <= a;
    sfrRd <= 1'b1;
    @(posedge core_clk);
    sfrRd <= 1'b0;
    @(posedge core_clk);
    v = sfrRdData;
  endtask

  // bounded wait until every enabled pending source is served
  task automatic drain(input int ackTarget);
    int k;
    k = 0;
    repeat (4) @(posedge core_clk);
    while ((((pendReq & shEn & ~served) != 8'h00) || depth != 2'h0 || nAck < ackTarget) && k < 500)
    begin
      @(posedge core_clk);
      k++;
    end
    if (k >= 500)
    begin
      $display("[ERR] drain expected idle seen busy");
      n_fail++;
      conclude();
    end
  endtask

  task automatic round(input logic [7:0] e, input logic [7:0] p, input logic [7:0] q);
    pendReq <= 8'h00;
    served <= 8'h00;
    shEn = e;
    shPr = p;
    wr(EIP_ADDR_ENABLE, e);
    wr(EIP_ADDR_PRIORITY, p);
    pendReq <= q;
    drain(0);
    chk("served", q & e, served);
  endtask

  // ==========================================================
  // every taken ack is compared with the expected winner
  always @(posedge core_clk)
  begin
    if (!rst && irqAck && irqValid)
    begin
      expV = expSrc(srcPending, shEn, shPr);
      chk("irqSrc", {5'h00, expV[2:0]}, {5'h00, irqSrc});
      chk("irqIsHigh", {7'h00, shPr[expV[2:0]]}, {7'h00, irqIsHigh});
      served[irqSrc] <= 1'b1;
      nAck++;
    end
  end

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial
  begin
    {rst, clkEn, sfrWr, sfrRd} = 4'hC;
    {sfrAddr, sfrWrData, pendReq, served, shEn, shPr} = 48'h0;
    ackDelay = 8'h00;
    svcLen = 8'h02;
    {n_fail, cmp_count, nAck} = '0;
    void'($urandom(12613));
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    rd(EIP_ADDR_ENABLE, rdv);
    chk("enable reset", 8'h00, rdv);
    chk("enableOut reset", 8'h00, enableOut);
    chk("priorityOut reset", EIP_PRIORITY_RST, priorityOut);
    $display("test reset done");
    repeat (6)
    begin
      d = 8'($urandom);
      wr(EIP_ADDR_ENABLE, d);
      wr(EIP_ADDR_PRIORITY, ~d);
      rd(EIP_ADDR_ENABLE, rdv);
      chk("enable rw", d, rdv);
      rd(EIP_ADDR_PRIORITY, rdv);
      chk("priority rw", ~d, rdv);
    end
    // write then read the priority register back to back, no idle cycle between
    @(posedge core_clk);
    sfrAddr <= EIP_ADDR_PRIORITY;
    sfrWrData <= d;
    sfrWr <= 1'b1;
    @(posedge core_clk);
    sfrWr <= 1'b0;
    sfrRd <= 1'b1;
    @(posedge core_clk);
    sfrRd <= 1'b0;
    @(posedge core_clk);
    chk("priority b2b", d, sfrRdData);
    wr(8'hE7, 8'hFF);
    rd(8'hE7, rdv);
    chk("unmapped", 8'h00, rdv);
    clkEn <= 1'b0;
    wr(EIP_ADDR_ENABLE, ~d);
    clkEn <= 1'b1;
    chk("frozen write", d, enableOut);
    $display("test registers done");
    round(8'h00, 8'hFF, 8'hFF);
    for (int i = 7; i >= 0; i--)
      round(8'h01 << i, 8'($urandom), 8'hFF);
    repeat (8)
    begin
      ackDelay = 8'($urandom_range(0, 3));
      round(8'($urandom), 8'($urandom), 8'($urandom));
    end
    $display("test masking done");
    svcLen = 8'h14;
    ackDelay = 8'h00;
    nAck = 0;
    round(8'h43, 8'h40, 8'h00);
    pendReq <= 8'h01;
    // stop while the low source is still in service, so the high one can nest
    for (int k = 0; k < 300 && depth != 2'h1; k++)
      @(posedge core_clk);
    chk("low in service", 8'h01, {6'h00, depth});
    pendReq <= 8'h41;
    for (int k = 0; k < 300 && depth != 2'h2; k++)
      @(posedge core_clk);
    chk("nest depth", 8'h02, {6'h00, depth});
    pendReq <= 8'h43;
    repeat (10)
    begin
      @(posedge core_clk);
      chk("held low", 8'h00, {7'h00, irqValid});
    end
    drain(3);
    chk("nest served", 8'h43, served);
    $display("test nesting done");
    conclude();
  end
endmodule
